// [core/alm_cfg.svh]
`ifndef ALM_CFG_SVH
`define ALM_CFG_SVH

// Directly addressed registers of the management map
`define ALM_ADDR_CTRL 8'h6e
`define ALM_ADDR_OFFS 8'h6f
`define ALM_ADDR_DATA 8'ha0

// Indirect control field layout
`define ALM_TBL_MSB 7
`define ALM_TBL_LSB 5
`define ALM_TBL_ACL 3'b010
`define ALM_PORT_MSB 3
`define ALM_PORT_LSB 0
`define ALM_PORT_FIRST 4'h1
`define ALM_PORT_LAST 4'h5

// Stored rule bytes
`define ALM_NUM_PORTS 5
`define ALM_NUM_BYTES 8
`define ALM_OFS_FIRST 8'h02
`define ALM_OFS_LAST 8'h09
`define ALM_IDX_B2 3'h0
`define ALM_IDX_B3 3'h1
`define ALM_IDX_B4 3'h2
`define ALM_IDX_B5 3'h3
`define ALM_IDX_B6 3'h4
`define ALM_IDX_B7 3'h5
`define ALM_IDX_B8 3'h6
`define ALM_IDX_B9 3'h7

// Byte six and seven fields, layer 4
`define ALM_MODE_MSB 2
`define ALM_MODE_LSB 1
`define ALM_PROTO_MSB_BIT 0
`define ALM_FME_BIT 0
`define ALM_PROTO_LOW_MSB 7
`define ALM_PROTO_LOW_LSB 1

// Reset values
`define ALM_BYTE_RST 8'h00
`define ALM_CTRL_RST 8'h00
`define ALM_OFFS_RST 8'h00

`endif

// [core/alm_match_fields.sv]
// Function
// (R1) Software selects table with control bits 7:5
// (R2) Control bits 3:0 pick one port's entry
// (R3) Offset picks byte, moved through data register
// (R4) L3 address bytes 15:8, 7:0 at 4,5
// (R5) L3 mask bytes at offsets 6, 7, 8, 9
// (R6) L4 max at 2,3; min at 4,5
// (R7) Range test on TCP port or sequence
// (R8) Mode: off, equal either, inside, outside
// (R9) Byte six bit 0 is protocol MSB
// (R10) L3 address bits 31:24 at offset 2
// (R11) Byte seven: protocol 6:0, flag match enable
// (R12) L3 match compares masked addresses
// (R13) Software keeps minimum not above maximum
`timescale 1ns/10ps
`default_nettype none
`include "alm_cfg.svh"

module alm_match_fields
  import alm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Management byte port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_we_in,
  input wire logic reg_re_in,
  output logic [7:0] reg_rdata_out,
  // Packet to match
  input wire alm_pkt_t pkt_in,
  // Match result
  output alm_res_t res_out
);

  //--------------------------------------------------------------
  // Reset release
  //--------------------------------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign rst_n = rst_s2_r;

  //--------------------------------------------------------------
  // Address decode
  //--------------------------------------------------------------
  logic ctrl_wr;
  logic offs_wr;
  logic data_hit;

  assign ctrl_wr = reg_we_in && (reg_addr_in == `ALM_ADDR_CTRL);
  assign offs_wr = reg_we_in && (reg_addr_in == `ALM_ADDR_OFFS);
  assign data_hit = (reg_addr_in == `ALM_ADDR_DATA);

  //--------------------------------------------------------------
  // Indirect control and offset
  //--------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] offs_r;
  logic [7:0] offs_nxt;
  logic sel_ok;
  logic [2:0] sel_port;
  logic [2:0] sel_idx;
  logic [3:0] port_field;
  logic [7:0] ofs_delta;

  assign port_field = ctrl_r[`ALM_PORT_MSB:`ALM_PORT_LSB];
  assign ofs_delta = offs_r - `ALM_OFS_FIRST;
  assign sel_idx = ofs_delta[2:0];
  assign sel_port = 3'(port_field - `ALM_PORT_FIRST);
  // Unselected table, port or offset makes the data register inert
  assign sel_ok = (ctrl_r[`ALM_TBL_MSB:`ALM_TBL_LSB] == `ALM_TBL_ACL) // see (R1)
    && (port_field >= `ALM_PORT_FIRST) && (port_field <= `ALM_PORT_LAST) // see (R2)
    && (offs_r >= `ALM_OFS_FIRST) && (offs_r <= `ALM_OFS_LAST); // see (R3)

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    offs_nxt = offs_r;
    if (ctrl_wr)
    begin
      ctrl_nxt = reg_wdata_in;
    end
    if (offs_wr)
    begin
      offs_nxt = reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `ALM_CTRL_RST;
      offs_r <= `ALM_OFFS_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      offs_r <= offs_nxt;
    end
  end

  //--------------------------------------------------------------
  // Rule byte storage
  //--------------------------------------------------------------
  // Raw bytes are kept; layer 3 or layer 4 meaning is applied on use
  logic [7:0] mem_r [`ALM_NUM_PORTS][`ALM_NUM_BYTES];
  logic [7:0] mem_nxt [`ALM_NUM_PORTS][`ALM_NUM_BYTES];
  logic data_wr;

  assign data_wr = reg_we_in && data_hit && sel_ok;

  genvar gp;
  genvar gb;
  generate
    for (gp = 0; gp < `ALM_NUM_PORTS; gp++)
    begin : g_port
      for (gb = 0; gb < `ALM_NUM_BYTES; gb++)
      begin : g_byte
        always_comb
        begin
          mem_nxt[gp][gb] = mem_r[gp][gb];
          if (data_wr && (sel_port == 3'(gp)) && (sel_idx == 3'(gb))) // see (R2)
          begin
            mem_nxt[gp][gb] = reg_wdata_in; // see (R3) see (R4) see (R5) see (R6) see (R10)
          end
        end

        always_ff @(posedge clk_sys_in or negedge rst_n)
        begin
          if (!rst_n)
          begin
            mem_r[gp][gb] <= `ALM_BYTE_RST;
          end
          else
          begin
            mem_r[gp][gb] <= mem_nxt[gp][gb];
          end
        end
      end
    end
  endgenerate

  //--------------------------------------------------------------
  // Read path
  //--------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_re_in)
    begin
      case (reg_addr_in)
        `ALM_ADDR_CTRL: rdata_nxt = ctrl_r;
        `ALM_ADDR_OFFS: rdata_nxt = offs_r;
        // Bytes outside the held range read as zero
        `ALM_ADDR_DATA: rdata_nxt = sel_ok ? mem_r[sel_port][sel_idx] : `ALM_BYTE_RST; // see (R3)
        default: rdata_nxt = `ALM_BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= `ALM_BYTE_RST;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  //--------------------------------------------------------------
  // Match evaluation
  //--------------------------------------------------------------
  logic pkt_port_ok;
  logic [2:0] pp;
  logic [31:0] rule_addr;
  logic [31:0] rule_mask;
  logic [15:0] rule_max;
  logic [15:0] rule_min;
  logic [15:0] l4_value;
  alm_cmp_mode_t cmp_mode;
  logic in_range;
  alm_res_t res_r;
  alm_res_t res_nxt;

  assign pkt_port_ok = (pkt_in.port < 3'(`ALM_NUM_PORTS));
  assign pp = pkt_port_ok ? pkt_in.port : 3'h0;
  assign rule_addr = {mem_r[pp][`ALM_IDX_B2], mem_r[pp][`ALM_IDX_B3],
                      mem_r[pp][`ALM_IDX_B4], mem_r[pp][`ALM_IDX_B5]}; // see (R4) see (R10)
  assign rule_mask = {mem_r[pp][`ALM_IDX_B6], mem_r[pp][`ALM_IDX_B7],
                      mem_r[pp][`ALM_IDX_B8], mem_r[pp][`ALM_IDX_B9]}; // see (R5)
  assign rule_max = {mem_r[pp][`ALM_IDX_B2], mem_r[pp][`ALM_IDX_B3]}; // see (R6)
  assign rule_min = {mem_r[pp][`ALM_IDX_B4], mem_r[pp][`ALM_IDX_B5]}; // see (R6)
  assign cmp_mode = alm_cmp_mode_t'(mem_r[pp][`ALM_IDX_B6][`ALM_MODE_MSB:`ALM_MODE_LSB]);
  assign l4_value = pkt_in.use_seq ? pkt_in.tcp_seq : pkt_in.tcp_port; // see (R7)
  // Assumes minimum not above maximum; otherwise inside never matches
  assign in_range = (l4_value >= rule_min) && (l4_value <= rule_max); // see (R13)

  //--------------------------------------------------------------
  // Layer 3 compare
  //--------------------------------------------------------------
  logic l3_hit;

  assign l3_hit = ((pkt_in.match_ip_address & rule_mask) == (rule_addr & rule_mask)); // see (R12)

  //--------------------------------------------------------------
  // Layer 4 range compare
  //--------------------------------------------------------------
  // Equality on either bound lets one rule name two single ports
  logic eq_either;
  logic l4_hit;

  assign eq_either = (l4_value == rule_max) || (l4_value == rule_min);

  always_comb
  begin
    case (cmp_mode) // see (R8)
      ALM_CMP_OFF:
      begin
        l4_hit = 1'b0;
      end
      ALM_CMP_EITHER:
      begin
        l4_hit = eq_either;
      end
      ALM_CMP_INSIDE:
      begin
        l4_hit = in_range;
      end
      ALM_CMP_OUTSIDE:
      begin
        l4_hit = !in_range;
      end
      default:
      begin
        l4_hit = 1'b0;
      end
    endcase
  end

  //--------------------------------------------------------------
  // Protocol and flag fields
  //--------------------------------------------------------------
  logic [7:0] proto_val;
  logic fme_val;

  assign proto_val = {mem_r[pp][`ALM_IDX_B6][`ALM_PROTO_MSB_BIT], // see (R9) see (R11)
                      mem_r[pp][`ALM_IDX_B7][`ALM_PROTO_LOW_MSB:`ALM_PROTO_LOW_LSB]};
  assign fme_val = mem_r[pp][`ALM_IDX_B7][`ALM_FME_BIT]; // see (R11)

  always_comb
  begin
    res_nxt = res_r;
    res_nxt.valid = pkt_in.valid && pkt_port_ok;
    if (pkt_in.valid && pkt_port_ok)
    begin
      res_nxt.l3_match = l3_hit;
      res_nxt.l4_match = l4_hit;
      res_nxt.ip_protocol_value = proto_val;
      res_nxt.tcp_flag_match_enable = fme_val;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_r <= '0;
    end
    else
    begin
      res_r <= res_nxt;
    end
  end

  assign res_out = res_r;

endmodule
`default_nettype wire

// [core/alm_pkg.sv]
package alm_pkg;

  typedef enum logic [1:0]
  {
    ALM_CMP_OFF = 2'b00,
    ALM_CMP_EITHER = 2'b01,
    ALM_CMP_INSIDE = 2'b10,
    ALM_CMP_OUTSIDE = 2'b11
  } alm_cmp_mode_t;

  // One packet presented for matching
  typedef struct packed
  {
    logic valid;
    logic [2:0] port;
    logic [31:0] match_ip_address;
    logic [15:0] tcp_port;
    logic [15:0] tcp_seq;
    logic use_seq;
  } alm_pkt_t;

  // Registered match result
  typedef struct packed
  {
    logic valid;
    logic l3_match;
    logic l4_match;
    logic [7:0] ip_protocol_value;
    logic tcp_flag_match_enable;
  } alm_res_t;

endpackage

// [testbench/alm_match_fields_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module alm_chk
  import alm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_we_in,
  input wire logic reg_re_in,
  input wire logic [7:0] reg_rdata_out,
  input wire alm_pkt_t pkt_in,
  input wire alm_res_t res_out
);
  // Shadow of control and offset, same one-cycle latency
  logic [7:0] ctl_r;
  logic [7:0] ofs_r;
  logic rda;
  logic tk;
  assign rda = reg_re_in && reg_addr_in == 8'ha0;
  assign tk = pkt_in.valid && pkt_in.port <= 3'h4;
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      {ctl_r, ofs_r} <= 16'h0000;
    else if (reg_we_in && reg_addr_in == 8'h6e)
      ctl_r <= reg_wdata_in;
    else if (reg_we_in && reg_addr_in == 8'h6f)
      ofs_r <= reg_wdata_in;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  res_take_a: assert property (tk |=> res_out.valid)
    else $error("no result");
  res_drop_a: assert property (!tk |=> !res_out.valid)
    else $error("stray result");
  res_hold_a: assert property (!res_out.valid |-> $stable(res_out[10:0]))
    else $error("result moved");
  unmapped_a: assert property (
    reg_re_in && !(reg_addr_in inside {8'h6e, 8'h6f, 8'ha0}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read");
  ctl_back_a: assert property (
    reg_we_in && reg_addr_in == 8'h6e ##2 reg_re_in
    && reg_addr_in == 8'h6e |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("ctrl readback");
  tbl_off_a: assert property (rda && ctl_r[7:5] != 3'b010 |=> reg_rdata_out == 8'h00)
    else $error("table leak");
  port_off_a: assert property (
    rda && !(ctl_r[3:0] inside {[4'h1:4'h5]}) |=> reg_rdata_out == 8'h00)
    else $error("port leak");
  ofs_off_a: assert property (
    rda && !(ofs_r inside {[8'h02:8'h09]}) |=> reg_rdata_out == 8'h00)
    else $error("offset leak");
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import alm_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_we_in = 1'b0;
  logic reg_re_in = 1'b0;
  logic [7:0] reg_rdata_out;
  alm_pkt_t pkt_in = '0;
  alm_res_t res_out;
  int error_cnt = 0;
  int checked = 0;
  int pi;
  logic [31:0] s = 32'h60;
  logic [31:0] r;
  logic [31:0] adr;
  logic [31:0] msk;
  logic [31:0] ip;
  logic [15:0] v;
  logic [15:0] mx;
  logic [15:0] mn;
  logic [7:0] b;
  logic [7:0] m [1:5][2:9];
  logic [15:0] bad [3] = '{16'h6104, 16'h4604, 16'h410a};
  alm_match_fields dut_u (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_we_in,
    .reg_re_in, .reg_rdata_out, .pkt_in, .res_out);
  initial
  begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic l4(input logic [15:0] x, input logic [1:0] md);
    case (md)
      2'b01: return x == mx || x == mn;
      2'b10: return x >= mn && x <= mx;
      2'b11: return x < mn || x > mx;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk_sys_in);
    {reg_we_in, reg_addr_in, reg_wdata_in} = {1'b1, ad, d};
    @(negedge clk_sys_in);
    reg_we_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(negedge clk_sys_in);
    {reg_re_in, reg_addr_in} = {1'b1, ad};
    @(negedge clk_sys_in);
    reg_re_in = 1'b0;
    chk(reg_rdata_out, e);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    wr(8'h6e, 8'h45);
    rd(8'h6e, 8'h45);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h6e, bad[i][15:8]);
      wr(8'h6f, bad[i][7:0]);
      wr(8'ha0, 8'hff);
      rd(8'ha0, 8'h00);
    end
    // Refused writes must not have landed in port 1
    wr(8'h6e, 8'h41);
    for (int o = 2; o < 10; o++)
    begin
      wr(8'h6f, 8'(o));
      rd(8'h6f, 8'(o));
      rd(8'ha0, 8'h00);
    end
    for (int k = 0; k < 4; k++)
    begin
      for (int i = 0; i < 80; i++)
      begin
        pi = (i % 40) / 8 + 1;
        wr(8'h6e, {4'h4, 4'(pi)});
        wr(8'h6f, 8'(i % 8 + 2));
        if (i < 40)
        begin
          b = 8'(rnd());
          // Keep min below max for the range codes
          b[7] = (i % 8 == 0) ? 1'b1 : (i % 8 == 2) ? 1'b0 : b[7];
          b[2:1] = (i % 8 == 4) ? 2'(k) : b[2:1];
          m[pi][i % 8 + 2] = b;
          wr(8'ha0, b);
        end
        else
          rd(8'ha0, m[pi][i % 8 + 2]);
      end
      repeat (30)
      begin
        r = rnd();
        pi = r[2:0] % 5 + 1;
        adr = {m[pi][2], m[pi][3], m[pi][4], m[pi][5]};
        msk = {m[pi][6], m[pi][7], m[pi][8], m[pi][9]};
        mx = {m[pi][2], m[pi][3]};
        mn = {m[pi][4], m[pi][5]};
        v = r[4:3] == 2'h0 ? mx : r[4:3] == 2'h1 ? mn : r[4:3] == 2'h2 ? mx + 16'h1 : 16'(rnd());
        ip = adr ^ (rnd() & (r[5] ? ~msk : 32'hffffffff));
        @(negedge clk_sys_in);
        pkt_in = {1'b1, r[2:0], ip, r[6] ? r[31:16] : v, r[6] ? v : r[31:16], r[6]};
        @(negedge clk_sys_in);
        pkt_in.valid = 1'b0;
        chk(res_out.valid, r[2:0] < 3'h5);
        if (r[2:0] < 3'h5)
        begin
          chk(res_out.l3_match, ((ip ^ adr) & msk) == 32'h0);
          chk(res_out.l4_match, l4(v, m[pi][6][2:1]));
          chk(res_out[8:0], {m[pi][6][0], m[pi][7]});
        end
      end
    end
    report_and_stop();
  end
endmodule
bind alm_match_fields alm_chk chk_u (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_we_in, .reg_re_in, .reg_rdata_out, .pkt_in, .res_out);
`default_nettype wire
